// ### rtl/eeprom_consts.vh
// Purpose: constants for the two-wire memory slave
// Assumes: 10 MHz sampling clock, 32-bit register bus
// Notes: device type code value is arbitrary
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH

// register byte offsets
`define REG_STATUS 4'h0
`define REG_FILTER 4'h4
`define REG_MEMADDR 4'h8
`define REG_MEMDATA 4'hc

// status fields
`define ST_BUSY_BIT 0
`define ST_ACTIVE_BIT 1
`define ST_WP_BIT 2
`define ST_SUPPLY_BIT 3
`define ST_PTR_LSB 16

// reset values
`define FILT_RST 3'h2
`define PTR_RST 10'h000

// device type code, arbitrary value
`define DEV_TYPE 4'h5

// received byte kinds
`define KIND_CTRL 2'h0
`define KIND_ADDR 2'h1
`define KIND_DATA 2'h2

// self-timed program cycle length in clocks; last byte offset in a 16-byte page
`define PROG_CYCLES 16'd1000
`define PAGE_LAST 4'hf

`endif

// ### rtl/serial_eeprom_read_path.v
// Purpose: two-wire bus slave for a 1 KiB byte memory
// Assumes: scl and sda sampled on clk_i, several samples per bit
// Notes: registers over Avalon-MM give status and a memory backdoor
`include "eeprom_consts.vh"

module serial_eeprom_read_path (
	input wire clk_i,
	input wire rst_i,
	input wire scl_i,
	input wire sda_i,
	output wire sda_o,
	output wire sda_oe_n_o,
	input wire wp_i,
	input wire supply_low_i,
	input wire [2:0] unused_strap_pins_i,
	input wire [3:0] avs_address_i,
	input wire avs_read_i,
	input wire avs_write_i,
	input wire [31:0] avs_writedata_i,
	output wire [31:0] avs_readdata_o,
	output wire avs_waitrequest_o
);

localparam S_IDLE = 5'h01;
localparam S_RX = 5'h02;
localparam S_ACK = 5'h04;
localparam S_TX = 5'h08;
localparam S_MACK = 5'h10;

reg [7:0] mem [0:1023];
reg [7:0] page_buf [0:15];

reg [1:0] scl_s_reg;
reg [1:0] sda_s_reg;
reg [1:0] wp_s_reg;
reg [1:0] low_s_reg;
reg scl_f_reg;
reg sda_f_reg;
reg scl_p_reg;
reg sda_p_reg;
reg [2:0] scl_cnt_reg;
reg [2:0] sda_cnt_reg;
reg [2:0] filt_len_reg;

reg [4:0] state_reg;
reg [1:0] kind_reg;
reg [3:0] bit_cnt_reg;
reg [7:0] shift_reg;
reg rw_reg;
reg [9:0] ptr_reg;
reg drive_low_reg;
reg mack_reg;
reg wrote_reg;
reg [15:0] valid_reg;
reg prog_start_reg;

reg prog_busy_reg;
reg [15:0] prog_cnt_reg;
reg [5:0] prog_page_reg;

reg [9:0] memaddr_reg;
reg ack_reg;
reg [31:0] rdata_reg;

wire wp_s;
wire low_s;
wire scl_rise;
wire scl_fall;
wire start_ev;
wire stop_ev;
wire [7:0] rd_byte;
wire bus_take;
wire copy_we;

// level accepted once it differs for len samples in a row
function stable_done;
	input [2:0] cnt;
	input [2:0] len;
	begin
		stable_done = ({1'b0, cnt} + 4'h1) >= {1'b0, len};
	end
endfunction

assign wp_s = wp_s_reg[1];
assign low_s = low_s_reg[1];
// straps never reach any logic, levels are don't care

// only ever pull low: output fixed at zero, enable low drives
assign sda_o = 1'b0;
assign sda_oe_n_o = ~drive_low_reg;

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		scl_s_reg <= 2'h3;
		sda_s_reg <= 2'h3;
		wp_s_reg <= 2'h0;
		low_s_reg <= 2'h0;
	end
	else
	begin
		scl_s_reg <= {scl_s_reg[0], scl_i};
		sda_s_reg <= {sda_s_reg[0], sda_i};
		wp_s_reg <= {wp_s_reg[0], wp_i};
		low_s_reg <= {low_s_reg[0], supply_low_i};
	end
end

// glitch filters; bus is idle high so filters reset high
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		scl_f_reg <= 1'b1;
		sda_f_reg <= 1'b1;
		scl_p_reg <= 1'b1;
		sda_p_reg <= 1'b1;
		scl_cnt_reg <= 3'h0;
		sda_cnt_reg <= 3'h0;
	end
	else
	begin
		scl_p_reg <= scl_f_reg;
		sda_p_reg <= sda_f_reg;
		if (scl_s_reg[1] == scl_f_reg)
			scl_cnt_reg <= 3'h0;
		else if (stable_done(scl_cnt_reg, filt_len_reg))
		begin
			scl_f_reg <= scl_s_reg[1];
			scl_cnt_reg <= 3'h0;
		end
		else
			scl_cnt_reg <= scl_cnt_reg + 3'h1;
		if (sda_s_reg[1] == sda_f_reg)
			sda_cnt_reg <= 3'h0;
		else if (stable_done(sda_cnt_reg, filt_len_reg))
		begin
			sda_f_reg <= sda_s_reg[1];
			sda_cnt_reg <= 3'h0;
		end
		else
			sda_cnt_reg <= sda_cnt_reg + 3'h1;
	end
end

// all bit timing comes from master clock edges
assign scl_rise = scl_f_reg & ~scl_p_reg;
assign scl_fall = ~scl_f_reg & scl_p_reg;
// data moving while clock high is framing, not data
assign start_ev = scl_f_reg & scl_p_reg & sda_p_reg & ~sda_f_reg;
assign stop_ev = scl_f_reg & scl_p_reg & ~sda_p_reg & sda_f_reg;
assign rd_byte = mem[ptr_reg];

always @(posedge clk_i)
begin
	prog_start_reg <= 1'b0;
	if (rst_i)
	begin
		state_reg <= S_IDLE;
		drive_low_reg <= 1'b0;
		kind_reg <= `KIND_CTRL;
		bit_cnt_reg <= 4'h0;
		shift_reg <= 8'h00;
		rw_reg <= 1'b0;
		ptr_reg <= `PTR_RST;
		mack_reg <= 1'b0;
		wrote_reg <= 1'b0;
		valid_reg <= 16'h0000;
	end
	else if (start_ev)
	begin
		// abandon any pending write; pointer stays as loaded
		state_reg <= S_RX;
		kind_reg <= `KIND_CTRL;
		bit_cnt_reg <= 4'h0;
		drive_low_reg <= 1'b0;
		wrote_reg <= 1'b0;
	end
	else if (stop_ev)
	begin
		state_reg <= S_IDLE;
		drive_low_reg <= 1'b0;
		wrote_reg <= 1'b0;
		// guard and supply checked at stop
		prog_start_reg <= wrote_reg & ~wp_s & ~low_s;
	end
	else
	begin
		case (state_reg)
		S_RX:
			if (scl_rise)
			begin
				shift_reg <= {shift_reg[6:0], sda_f_reg};
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
			else if (scl_fall && bit_cnt_reg == 4'h8)
			begin
				bit_cnt_reg <= 4'h0;
				state_reg <= S_ACK;
				drive_low_reg <= 1'b1;
				case (kind_reg)
				`KIND_CTRL:
					if (shift_reg[7:4] == `DEV_TYPE && !prog_busy_reg)
					begin
						rw_reg <= shift_reg[0];
						ptr_reg[9:8] <= shift_reg[2:1];
						if (!shift_reg[0])
							valid_reg <= 16'h0000;
					end
					else
					begin
						// busy or foreign code: stay silent
						state_reg <= S_IDLE;
						drive_low_reg <= 1'b0;
					end
				`KIND_ADDR:
					ptr_reg[7:0] <= shift_reg;
				default:
				begin
					page_buf[ptr_reg[3:0]] <= shift_reg;
					valid_reg[ptr_reg[3:0]] <= 1'b1;
					ptr_reg[3:0] <= ptr_reg[3:0] + 4'h1;
					wrote_reg <= 1'b1;
				end
				endcase
			end
		S_ACK:
			if (scl_fall)
			begin
				bit_cnt_reg <= 4'h0;
				if (rw_reg)
				begin
					state_reg <= S_TX;
					shift_reg <= rd_byte;
					drive_low_reg <= ~rd_byte[7];
					ptr_reg <= ptr_reg + 10'h001;
				end
				else
				begin
					state_reg <= S_RX;
					drive_low_reg <= 1'b0;
					if (kind_reg == `KIND_CTRL)
						kind_reg <= `KIND_ADDR;
					else
						kind_reg <= `KIND_DATA;
				end
			end
		S_TX:
			if (scl_fall)
			begin
				if (bit_cnt_reg == 4'h7)
				begin
					state_reg <= S_MACK;
					drive_low_reg <= 1'b0;
				end
				else
				begin
					shift_reg <= {shift_reg[6:0], 1'b0};
					drive_low_reg <= ~shift_reg[6];
					bit_cnt_reg <= bit_cnt_reg + 4'h1;
				end
			end
		S_MACK:
			if (scl_rise)
				mack_reg <= ~sda_f_reg;
			else if (scl_fall)
			begin
				bit_cnt_reg <= 4'h0;
				if (mack_reg)
				begin
					// next sequential byte; wraps over whole array
					state_reg <= S_TX;
					shift_reg <= rd_byte;
					drive_low_reg <= ~rd_byte[7];
					ptr_reg <= ptr_reg + 10'h001;
				end
				else
					state_reg <= S_IDLE;
			end
		S_IDLE:
			drive_low_reg <= 1'b0;
		default:
		begin
			state_reg <= S_IDLE;
			drive_low_reg <= 1'b0;
		end
		endcase
	end
end

// program cycle: one buffered byte per clock, then wait out the rest
always @(posedge clk_i)
begin
	if (rst_i)
	begin
		prog_busy_reg <= 1'b0;
		prog_cnt_reg <= 16'h0000;
		prog_page_reg <= 6'h00;
	end
	else if (prog_start_reg)
	begin
		prog_busy_reg <= 1'b1;
		prog_cnt_reg <= 16'h0000;
		prog_page_reg <= ptr_reg[9:4];
	end
	else if (prog_busy_reg)
	begin
		prog_cnt_reg <= prog_cnt_reg + 16'h0001;
		if (prog_cnt_reg == `PROG_CYCLES - 16'h0001)
			prog_busy_reg <= 1'b0;
	end
end

// supply drop mid-cycle still suppresses the array write
assign copy_we = prog_busy_reg && prog_cnt_reg[15:4] == 12'h000 &&
	valid_reg[prog_cnt_reg[3:0]] && !low_s;
assign bus_take = (avs_read_i | avs_write_i) & ~ack_reg;

always @(posedge clk_i)
begin
	if (copy_we)
		mem[{prog_page_reg, prog_cnt_reg[3:0]}] <=
			page_buf[prog_cnt_reg[3:0]];
	else if (ack_reg && avs_write_i && avs_address_i == `REG_MEMDATA)
		mem[memaddr_reg] <= avs_writedata_i[7:0];
end

// one wait state per access; unmapped reads zero, writes dropped
assign avs_waitrequest_o = bus_take;
assign avs_readdata_o = rdata_reg;

always @(posedge clk_i)
begin
	if (rst_i)
	begin
		ack_reg <= 1'b0;
		rdata_reg <= 32'h00000000;
		filt_len_reg <= `FILT_RST;
		memaddr_reg <= 10'h000;
	end
	else
	begin
		ack_reg <= bus_take;
		if (bus_take && avs_read_i)
		begin
			rdata_reg <= 32'h00000000;
			case (avs_address_i)
			`REG_STATUS:
			begin
				rdata_reg[`ST_BUSY_BIT] <= prog_busy_reg;
				rdata_reg[`ST_ACTIVE_BIT] <= state_reg != S_IDLE;
				rdata_reg[`ST_WP_BIT] <= wp_s;
				rdata_reg[`ST_SUPPLY_BIT] <= low_s;
				rdata_reg[`ST_PTR_LSB+9:`ST_PTR_LSB] <= ptr_reg;
			end
			`REG_FILTER:
				rdata_reg[2:0] <= filt_len_reg;
			`REG_MEMADDR:
				rdata_reg[9:0] <= memaddr_reg;
			`REG_MEMDATA:
				rdata_reg[7:0] <= mem[memaddr_reg];
			default:
				rdata_reg <= 32'h00000000;
			endcase
		end
		if (ack_reg && avs_write_i)
		begin
			if (avs_address_i == `REG_FILTER)
				filt_len_reg <= avs_writedata_i[2:0];
			if (avs_address_i == `REG_MEMADDR)
				memaddr_reg <= avs_writedata_i[9:0];
		end
	end
end

endmodule

// ### tb/eeprom_props.sv
// Purpose: line and register bus checks for the memory slave
// Assumes: one clock domain, synchronous reset
// Notes: sees top ports only
module eeprom_props (
	input logic clk_i,
	input logic rst_i,
	input logic scl_i,
	input logic sda_o,
	input logic sda_oe_n_o,
	input logic [3:0] avs_address_i,
	input logic avs_read_i,
	input logic avs_write_i,
	input logic [31:0] avs_readdata_o,
	input logic avs_waitrequest_o
);
	timeunit 1ns;
	timeprecision 1ns;
	wire req = avs_read_i | avs_write_i;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence one_wait;
		avs_waitrequest_o ##1 !avs_waitrequest_o;
	endsequence
	low_only_a: assert property (sda_o == 1'b0)
		else $error("data line driven high");
	rst_free_a: assert property ($fell(rst_i) |-> sda_oe_n_o)
		else $error("line held after reset");
	one_wait_a: assert property ($rose(req) |-> one_wait)
		else $error("wait state count wrong");
	idle_wait_a: assert property (!req |-> !avs_waitrequest_o)
		else $error("wait without request");
	hole_zero_a: assert property (avs_read_i && !avs_waitrequest_o &&
		avs_address_i[1:0] != 2'h0 |-> avs_readdata_o == 32'h0)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!(avs_read_i && avs_waitrequest_o)
		|=> $stable(avs_readdata_o))
		else $error("read data moved");
	// answer lags scl by the synchroniser, so only long high is judged
	scl_high_a: assert property ($changed(sda_oe_n_o) |->
		!(scl_i && $past(scl_i) && $past(scl_i, 2)))
		else $error("line moved in clock high");
	pull_hold_a: assert property ($fell(sda_oe_n_o) |=>
		!sda_oe_n_o [*4])
		else $error("pull shorter than a bit");
endmodule
bind serial_eeprom_read_path eeprom_props i_eeprom_props (.clk_i(clk_i),
	.rst_i(rst_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o));

// ### tb/bus_master_model.sv
// Purpose: two-wire bus master for the slave
// Assumes: bit time 8 clocks, pull-up on data line
// Notes: clock line stands high between frames
module bus_master_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_oe_n_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		scl_o = 1'b1;
		sda_oe_n_o = 1'b1;
	end
	task automatic w(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic start();
		if (!sda_i)
		begin
			scl_o <= 1'b0;
			w(1);
			sda_oe_n_o <= 1'b1;
			w(6);
			scl_o <= 1'b1;
			w(3);
		end
		sda_oe_n_o <= 1'b0;
		w(3);
	endtask
	// b[0] is the ack slot: 1 releases it
	task automatic xfer(input logic [8:0] b, output logic [8:0] q);
		for (int i = 8; i >= 0; i--)
		begin
			scl_o <= 1'b0;
			w(1);
			sda_oe_n_o <= b[i];
			w(4);
			scl_o <= 1'b1;
			w(3);
			q[i] = sda_i;
		end
	endtask
	task automatic stop();
		scl_o <= 1'b0;
		w(1);
		sda_oe_n_o <= 1'b0;
		w(6);
		scl_o <= 1'b1;
		w(3);
		sda_oe_n_o <= 1'b1;
		w(6);
	endtask
endmodule

// ### tb/serial_eeprom_read_path_tb.sv
// Purpose: self-checking bench for the memory slave
// Assumes: 100 ns clock, 800 ns bit time
// Notes: program cycle waited out by fixed count
`include "eeprom_consts.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
	$display("unexpected at %0t: %h %h", $time, a, b); end end
module serial_eeprom_read_path_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wp_i = 1'b1;
	logic supply_low_i = 1'b0;
	logic [2:0] straps = 3'h0;
	logic [3:0] adr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] q;
	logic [8:0] r;
	wire [31:0] rdat;
	wire waitrq, scl, m_oe_n, d_oe_n, d_o;
	wire sda = (d_oe_n | d_o) & m_oe_n;
	int num_errors = 0;
	int tests_run = 0;
	always #50 clk_i = ~clk_i;
	serial_eeprom_read_path i_serial_eeprom_read_path (.clk_i(clk_i),
		.rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(d_o),
		.sda_oe_n_o(d_oe_n), .wp_i(wp_i), .supply_low_i(supply_low_i),
		.unused_strap_pins_i(straps), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
		.avs_readdata_o(rdat), .avs_waitrequest_o(waitrq));
	bus_master_model i_bus_master_model (.clk_i(clk_i), .sda_i(sda),
		.scl_o(scl), .sda_oe_n_o(m_oe_n));
	task automatic results();
		if (num_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic acc(input logic w, input logic [3:0] a, input int d);
		int n;
		@(posedge clk_i);
		rd <= !w;
		wr <= w;
		adr <= a;
		wdat <= d;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_i);
			if (waitrq === 1'b0)
				break;
		end
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n == 20)
		begin
			num_errors++;
			results();
		end
	endtask
	task automatic x(input logic [8:0] b);
		i_bus_master_model.xfer(b, r);
	endtask
	initial
	begin
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		acc(0, `REG_FILTER, 0);
		`CHK(q[2:0], `FILT_RST)
		// one sample keeps the answer inside the low half of a bit
		acc(1, `REG_FILTER, 1);
		acc(0, 4'h2, 0);
		`CHK(q, 32'h0)
		for (int i = 0; i < 3; i++)
		begin
			acc(1, `REG_MEMADDR, 32'h1fe + i);
			acc(1, `REG_MEMDATA, 32'h3c + i);
		end
		acc(1, `REG_MEMADDR, 32'h10);
		acc(1, `REG_MEMDATA, 0);
		i_bus_master_model.start();
		x({`DEV_TYPE, 3'b101, 1'b0, 1'b1});
		`CHK(r[0], 1'b0)
		x({8'hfe, 1'b1});
		`CHK(r[0], 1'b0)
		i_bus_master_model.start();
		x({`DEV_TYPE, 3'b101, 1'b1, 1'b1});
		`CHK(r[0], 1'b0)
		for (int i = 0; i < 3; i++)
		begin
			x({8'hff, i == 2});
			`CHK(r[8:1], 8'(8'h3c + i))
		end
		i_bus_master_model.stop();
		`CHK(d_oe_n, 1'b1)
		acc(0, `REG_STATUS, 0);
		`CHK(q[25:16], 10'h201)
		`CHK(q[0], 1'b0)
		`CHK(q[3:1], 3'h2)
		i_bus_master_model.start();
		x({~`DEV_TYPE, 4'h0, 1'b1});
		`CHK(r[0], 1'b1)
		i_bus_master_model.stop();
		for (int k = 0; k < 3; k++)
		begin
			wp_i <= k == 0;
			supply_low_i <= k == 1;
			straps <= 3'(k + 5);
			i_bus_master_model.start();
			x({`DEV_TYPE, 4'h0, 1'b1});
			x({8'h10, 1'b1});
			x({8'(8'h40 + k), 1'b1});
			i_bus_master_model.stop();
			i_bus_master_model.start();
			x({`DEV_TYPE, 4'h0, 1'b1});
			`CHK(r[0], 1'(k == 2))
			i_bus_master_model.stop();
			repeat (1100) @(posedge clk_i);
			acc(1, `REG_MEMADDR, 32'h10);
			acc(0, `REG_MEMDATA, 0);
			`CHK(q[7:0], k == 2 ? 8'h42 : 8'h00)
		end
		// second byte must wrap to the start of its page
		i_bus_master_model.start();
		x({`DEV_TYPE, 4'h0, 1'b1});
		x({8'h2f, 1'b1});
		x({8'h51, 1'b1});
		x({8'h52, 1'b1});
		i_bus_master_model.stop();
		repeat (1100) @(posedge clk_i);
		acc(1, `REG_MEMADDR, 32'h2f);
		acc(0, `REG_MEMDATA, 0);
		`CHK(q[7:0], 8'h51)
		acc(1, `REG_MEMADDR, 32'h20);
		acc(0, `REG_MEMDATA, 0);
		`CHK(q[7:0], 8'h52)
		results();
	end
endmodule
